// *** bench/ttc_ext_src.sv ***
// external count source model: six count pins, low outside requested bursts
// assumes clk is the block's system clock; the block samples pins on clk through a three-stage synchroniser
`timescale 1ns/100ps
module ttc_ext_src (
  input  wire logic       clk,
  output logic      [5:0] pins
);
  // ---------------------------------------------------------------------
  // burst generator
  // ---------------------------------------------------------------------
  initial pins = 6'h00;

  // four clocks high, four low: a synchronised count never sees two
  // edges in one instruction cycle, so no edge is lost
  task automatic burst(input int lane, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk);
      pins[lane] <= 1'b1;
      repeat (4) @(posedge clk);
      pins[lane] <= 1'b0;
    end
  endtask
endmodule

// *** bench/ttc_top_tb.sv ***
// self-checking bench for the timer/counter: apb driver, scoreboard, tests
// assumes ttc_ext_src drives the count pins; no other partner on the pins
`timescale 1ns/100ps
module ttc_top_tb;
  import ttc_pkg::*;
  typedef struct packed {logic chk; logic err; logic [31:0] d;} ttc_exp_t;
  logic              clk        = 1'b0;
  logic              rst_n      = 1'b0;
  logic              psel       = 1'b0;
  logic              penable    = 1'b0;
  logic              pwrite     = 1'b0;
  logic              sleep      = 1'b0;
  logic [ADDR_W-1:0] paddr      = '0;
  logic [31:0]       pwdata     = '0;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              pready;
  logic              pslverr;
  logic              tmr_out;
  logic              pulse;
  logic              flag;
  logic              pulse_q    = 1'b0;
  logic [5:0]        pins;
  logic [7:0]        per;
  logic [7:0]        ps;
  logic [7:0]        v0;
  ttc_exp_t          exp_q[$];
  int                num_errors = 0;
  int                n_compared = 0;
  int                n_pulse    = 0;

  // ---------------------------------------------------------------------
  // clock, design, partner
  // ---------------------------------------------------------------------
  always #2.5 clk = ~clk;

  ttc_top dut_u (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_CLK_IN(pins), .SLEEP(sleep), .TIMER_OUT(tmr_out),
    .MATCH_OUTPUT_PULSE(pulse), .MATCH_EVENT_FLAG(flag)
  );

  ttc_ext_src src_u (
    .clk(clk),
    .pins(pins)
  );

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one apb transfer; the note of what to expect goes in before setup
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic c, input logic e);
    exp_q.push_back('{c, e, d});
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= w ? d : 32'h0;
    @(posedge clk);
    penable <= 1'b1;
    // hold the access phase until the slave answers; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0, 1'b0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b0, a, d, 1'b1, 1'b0);
  endtask

  // edges on one pin, then time for synchroniser and count to land
  task automatic edges(input int lane, input int n);
    src_u.burst(lane, n);
    repeat (8) @(posedge clk);
  endtask

  // ---------------------------------------------------------------------
  // scoreboard: oldest note against each completed transfer
  // ---------------------------------------------------------------------
  always @(posedge clk) begin
    ttc_exp_t e;
    pulse_q <= pulse;
    if (pulse === 1'b1 && pulse_q !== 1'b1) n_pulse <= n_pulse + 1;
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e.chk) chk(prdata, e.d);
      chk({31'h0, pslverr}, {31'h0, e.err});
    end
  end

  // watchdog: the whole sequence needs well under half this span
  initial begin
    #400000;
    num_errors++;
    conclude();
  end

  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial begin
    void'($urandom(32'h6e371df4));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(OFS_COUNT_LOW, {24'h0, RST_COUNT_LOW});
    rdc(OFS_PERIOD_HIGH, {24'h0, RST_PERIOD_HIGH});
    rdc(OFS_PRIMARY, 32'h0);
    rdc(OFS_CLOCKING, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    xfer(1'b0, 8'h14, 32'h0, 1'b1, 1'b1);
    $display("test reset done");
    // 8-bit match with random period and postscale, async pin counting
    per = 8'($urandom_range(4, 1));
    ps = 8'($urandom_range(2, 0));
    wr(OFS_CLOCKING, 32'h50);
    wr(OFS_PERIOD_HIGH, {24'h0, per});
    rdc(OFS_PERIOD_HIGH, {24'h0, per});
    wr(OFS_COUNT_LOW, 32'h0);
    wr(OFS_PRIMARY, {24'h0, 8'h80 | ps});
    edges(0, (ps + 1) * (per + 1) + 1);
    chk(n_pulse, 32'h1);
    chk({31'h0, tmr_out}, 32'h1);
    chk({31'h0, flag}, 32'h1);
    rdc(OFS_COUNT_LOW, 32'h1);
    rdc(OFS_STATUS, 32'h1);
    rdc(OFS_PRIMARY, {24'h0, 8'hA0 | ps});
    wr(OFS_STATUS, 32'h1);
    rdc(OFS_STATUS, 32'h0);
    chk({31'h0, flag}, 32'h0);
    $display("test match done");
    // every prescale ratio of the first four, then clearing by writes
    wr(OFS_PERIOD_HIGH, 32'hFF);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CLOCKING, 32'h50 | k);
      wr(OFS_COUNT_LOW, 32'h0);
      edges(0, 3 << k);
      rdc(OFS_COUNT_LOW, 32'h3);
    end
    wr(OFS_CLOCKING, 32'h51);
    edges(0, 1);
    wr(OFS_PRIMARY, 32'h80);
    edges(0, 1);
    rdc(OFS_COUNT_LOW, 32'h3);
    $display("test prescale done");
    // each external source code counts its own pin only
    for (int c = 2; c < 8; c++) begin
      wr(OFS_CLOCKING, (c << 5) | 32'h10);
      wr(OFS_COUNT_LOW, 32'h0);
      edges((c - 1) % 6, 1);
      edges(c - 2, 2);
      rdc(OFS_COUNT_LOW, 32'h2);
    end
    $display("test sources done");
    // sleep halts sync counting, async pin counting carries on
    sleep <= 1'b1;
    wr(OFS_CLOCKING, 32'h20);
    wr(OFS_COUNT_LOW, 32'h0);
    repeat (40) @(posedge clk);
    rdc(OFS_COUNT_LOW, 32'h0);
    wr(OFS_CLOCKING, 32'h50);
    wr(OFS_COUNT_LOW, 32'h0);
    edges(0, 3);
    rdc(OFS_COUNT_LOW, 32'h3);
    sleep <= 1'b0;
    // instruction clock: snapshots 160 clocks apart differ by 40
    wr(OFS_CLOCKING, 32'h0);
    wr(OFS_COUNT_LOW, 32'h0);
    xfer(1'b0, OFS_COUNT_LOW, 32'h0, 1'b0, 1'b0);
    v0 = rd[7:0];
    repeat (157) @(posedge clk);
    xfer(1'b0, OFS_COUNT_LOW, 32'h0, 1'b0, 1'b0);
    chk({24'h0, 8'(rd[7:0] - v0)}, 32'd40);
    $display("test sleep and timer done");
    // 16-bit: buffered high byte on low write and low read, rollover
    wr(OFS_PRIMARY, 32'h90);
    wr(OFS_CLOCKING, 32'h50);
    wr(OFS_STATUS, 32'h1);
    wr(OFS_PERIOD_HIGH, 32'hFF);
    wr(OFS_COUNT_LOW, 32'hFE);
    wr(OFS_PERIOD_HIGH, 32'h12);
    rdc(OFS_COUNT_LOW, 32'hFE);
    rdc(OFS_PERIOD_HIGH, 32'hFF);
    edges(0, 2);
    rdc(OFS_COUNT_LOW, 32'h0);
    rdc(OFS_PERIOD_HIGH, 32'h0);
    rdc(OFS_STATUS, 32'h1);
    chk(n_pulse, 32'h2);
    chk({31'h0, tmr_out}, 32'h0);
    chk({31'h0, flag}, 32'h1);
    $display("test wide done");
    conclude();
  end
endmodule

// *** logic/ttc_edge_sync.sv ***
// three-stage synchroniser with rising-edge detect, one lane per input
// assumes inputs are asynchronous to clk
`timescale 1ns/100ps
module ttc_edge_sync #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] rise
);
  import ttc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ttc_sync_t;

  ttc_sync_t q, d;

  // ---------------------------------------------------------------------
  // filter: a change counts only when stages two and three agree
  // ---------------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  assign rise = q.s2 & q.s3 & ~q.lvl;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // one rising pin edge is one count: the settled level blocks a repeat
  rise_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rise != '0) |=> ((rise & $past(rise)) == '0))
    else $error("one pin edge reported twice");
endmodule

// *** logic/ttc_pkg.sv ***
// constants for the 8/16-bit timer/counter: register map, fields, resets
// assumes a 32-bit apb slave with byte addresses and one word per register
package ttc_pkg;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_COUNT_LOW   = 8'h00;
  localparam logic [7:0]  OFS_PERIOD_HIGH = 8'h04;
  localparam logic [7:0]  OFS_PRIMARY     = 8'h08;
  localparam logic [7:0]  OFS_CLOCKING    = 8'h0C;
  localparam logic [7:0]  OFS_STATUS      = 8'h10;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int          PRI_ENABLE_BIT  = 7;
  localparam int          PRI_OUT_BIT     = 5;
  localparam int          PRI_WIDE_BIT    = 4;
  localparam int          CLK_SRC_LSB     = 5;
  localparam int          CLK_ASYNC_BIT   = 4;
  localparam int          STAT_FLAG_BIT   = 0;

  // ---------------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------------
  localparam logic [7:0]  RST_COUNT_LOW   = 8'h00;
  localparam logic [7:0]  RST_PERIOD_HIGH = 8'hFF;
  localparam logic [1:0]  INSTR_DIV_LAST  = 2'h3;   // fosc/4: four clocks per cycle
  localparam logic [2:0]  SRC_INSTR       = 3'h0;
  localparam logic [2:0]  SRC_FOSC        = 3'h1;
  localparam logic [2:0]  SRC_EXT_FIRST   = 3'h2;
  localparam int          EXT_SRC_N       = 6;
  localparam int          PRESCALE_BITS   = 15;

endpackage

// *** logic/ttc_prescale.sv ***
// 15-bit power-of-two prescaler, select 0 passes every tick
// assumes tick_in is a single-cycle pulse on clk
`timescale 1ns/100ps
module ttc_prescale #(
  parameter int BITS = 15
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick_in,
  input  wire logic       clear,
  input  wire logic [3:0] sel,
  output logic            tick_out
);
  import ttc_pkg::*;

  typedef struct packed {
    logic [BITS-1:0] cnt;
  } ttc_pre_t;

  ttc_pre_t        q, d;
  logic [BITS-1:0] mask;

  // mask of the low sel bits; a full mask at a tick ends one divided period
  always_comb begin
    mask = BITS'((17'h00001 << sel) - 17'h00001);
    tick_out = tick_in & ((q.cnt & mask) == mask);
    d = q;
    if (clear) begin
      d.cnt = '0;
    end else if (tick_in) begin
      d.cnt = q.cnt + BITS'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  pre_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clear |=> (q.cnt == '0))
    else $error("prescaler not cleared");

  pre_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sel == 4'h0) |-> (tick_out == tick_in))
    else $error("1:1 prescale does not pass ticks");
endmodule

// *** logic/ttc_top.sv ***
// 8/16-bit timer/counter with prescaler, postscaler and apb registers
// assumes apb3 master on CLK; EXT_CLK_IN pins are asynchronous to CLK
`timescale 1ns/100ps
module ttc_top (
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [ttc_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]                 PWDATA,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  input  wire logic [ttc_pkg::EXT_SRC_N-1:0] EXT_CLK_IN,
  input  wire logic                        SLEEP,
  output logic                             TIMER_OUT,
  output logic                             MATCH_OUTPUT_PULSE,
  output logic                             MATCH_EVENT_FLAG
);
  import ttc_pkg::*;

  typedef struct packed {
    logic [7:0] count_low_byte;
    logic [7:0] count_high;
    logic [7:0] period_or_high_buffer;
    logic [7:0] period_buf;
    logic       enable;
    logic       wide_mode_select;
    logic [3:0] postscale_select;
    logic [2:0] clock_source_select;
    logic       async_count_select;
    logic [3:0] prescale_select;
    logic [1:0] instr_div;
    logic       pend;
    logic [3:0] post_cnt;
    logic       timer_out;
    logic       pulse;
    logic       match_event_flag;
    logic [7:0] rdata;
    logic [7:0] snap_high;
  } ttc_state_t;

  ttc_state_t           q, d;
  logic [EXT_SRC_N-1:0] ext_rise;
  logic                 setup, access, hit;
  logic                 wr_low, wr_period, wr_pri, wr_clk, wr_stat, rd_low;
  logic                 clr_scalers;
  logic                 instr_tick, src_tick, pre_tick, count_tick;
  logic                 roll_event, post_event;
  logic [7:0]           rd_mux;
  logic [15:0]          wide_next;

  // ---------------------------------------------------------------------
  // pin synchroniser and prescaler
  // ---------------------------------------------------------------------
  ttc_edge_sync #(
    .W (EXT_SRC_N)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .din   (EXT_CLK_IN),
    .rise  (ext_rise)
  );

  ttc_prescale #(
    .BITS (PRESCALE_BITS)
  ) u_pre (
    .clk      (CLK),
    .rst_n    (RST_N),
    .tick_in  (src_tick & q.enable),
    .clear    (clr_scalers),
    .sel      (q.prescale_select),
    .tick_out (pre_tick)
  );

  // ---------------------------------------------------------------------
  // apb decode; zero wait states, so every access phase completes
  // ---------------------------------------------------------------------
  always_comb begin
    setup  = PSEL & ~PENABLE;
    access = PSEL & PENABLE;
    hit    = (PADDR == OFS_COUNT_LOW) || (PADDR == OFS_PERIOD_HIGH) ||
             (PADDR == OFS_PRIMARY) || (PADDR == OFS_CLOCKING) ||
             (PADDR == OFS_STATUS);
    wr_low    = access & PWRITE & (PADDR == OFS_COUNT_LOW);
    wr_period = access & PWRITE & (PADDR == OFS_PERIOD_HIGH);
    wr_pri    = access & PWRITE & (PADDR == OFS_PRIMARY);
    wr_clk    = access & PWRITE & (PADDR == OFS_CLOCKING);
    wr_stat   = access & PWRITE & (PADDR == OFS_STATUS);
    rd_low    = access & ~PWRITE & (PADDR == OFS_COUNT_LOW);
    clr_scalers = wr_low | wr_pri | wr_clk;
  end

  // read mux; scaler counters have no address at all
  always_comb begin
    unique case (PADDR)
      OFS_COUNT_LOW:   rd_mux = q.count_low_byte;
      OFS_PERIOD_HIGH: rd_mux = q.period_or_high_buffer;
      OFS_PRIMARY:     rd_mux = {q.enable, 1'b0, q.timer_out, q.wide_mode_select,
                                 q.postscale_select};
      OFS_CLOCKING:    rd_mux = {q.clock_source_select, q.async_count_select,
                                 q.prescale_select};
      OFS_STATUS:      rd_mux = {7'h00, q.match_event_flag};
      default:         rd_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------
  // clock source selection and counting tick
  // ---------------------------------------------------------------------
  always_comb begin
    // the system oscillator stops in sleep, so both internal sources halt
    instr_tick = (q.instr_div == INSTR_DIV_LAST) & ~SLEEP;
    if (q.clock_source_select == SRC_INSTR) begin
      src_tick = instr_tick;
    end else if (q.clock_source_select == SRC_FOSC) begin
      src_tick = ~SLEEP;
    end else begin
      src_tick = ext_rise[q.clock_source_select - SRC_EXT_FIRST];
    end
    // async counts prescaled edges at once; sync waits for an instruction cycle
    if (q.async_count_select) begin
      count_tick = pre_tick;
    end else begin
      count_tick = instr_tick & (q.pend | pre_tick);
    end
  end

  // ---------------------------------------------------------------------
  // next state: registers, counter, postscaler, output
  // ---------------------------------------------------------------------
  always_comb begin
    d = q;
    roll_event = 1'b0;
    post_event = 1'b0;
    wide_next  = {q.count_high, q.count_low_byte} + 16'h0001;
    d.instr_div = q.instr_div + 2'h1;

    // sync mode remembers an edge until the next instruction cycle;
    // a second edge inside one cycle is lost, hence the rate limit
    if (clr_scalers || !q.enable || q.async_count_select || count_tick) begin
      d.pend = 1'b0;
    end else if (pre_tick) begin
      d.pend = 1'b1;
    end

    // register writes and setup-phase read capture
    if (setup) begin
      d.rdata     = rd_mux;
      d.snap_high = q.count_high;
    end
    if (wr_period) begin
      d.period_or_high_buffer = PWDATA[7:0];
    end
    if (rd_low && q.wide_mode_select) begin
      d.period_or_high_buffer = q.snap_high;
    end
    if (wr_pri) begin
      d.enable           = PWDATA[PRI_ENABLE_BIT];
      d.wide_mode_select = PWDATA[PRI_WIDE_BIT];
      d.postscale_select = PWDATA[3:0];
    end
    if (wr_clk) begin
      d.clock_source_select = PWDATA[CLK_SRC_LSB +: 3];
      d.async_count_select  = PWDATA[CLK_ASYNC_BIT];
      d.prescale_select     = PWDATA[3:0];
    end

    // counter: a software write wins over a count in the same cycle
    if (wr_low) begin
      d.count_low_byte = PWDATA[7:0];
      d.period_buf     = q.period_or_high_buffer;
      if (q.wide_mode_select) begin
        d.count_high = q.period_or_high_buffer;
      end
    end else if (count_tick) begin
      if (q.wide_mode_select) begin
        d.count_low_byte = wide_next[7:0];
        d.count_high     = wide_next[15:8];
        roll_event       = &{q.count_high, q.count_low_byte};
      end else if (q.count_low_byte == q.period_buf) begin
        d.count_low_byte = 8'h00;
        d.period_buf     = q.period_or_high_buffer;
        roll_event       = 1'b1;
      end else begin
        d.count_low_byte = q.count_low_byte + 8'h01;
      end
    end

    // postscaler: one event out of every postscale_select + 1
    if (clr_scalers) begin
      d.post_cnt = 4'h0;
    end else if (roll_event) begin
      if (q.post_cnt == q.postscale_select) begin
        d.post_cnt = 4'h0;
        post_event = 1'b1;
      end else begin
        d.post_cnt = q.post_cnt + 4'h1;
      end
    end

    // pulse lasts until the next counting tick, one prescaled period
    if (post_event) begin
      d.pulse     = 1'b1;
      d.timer_out = ~q.timer_out;
    end else if (count_tick || !q.enable) begin
      d.pulse = 1'b0;
    end

    // write one clears the flag; a same-cycle event still sets it
    if (wr_stat && PWDATA[STAT_FLAG_BIT]) begin
      d.match_event_flag = 1'b0;
    end
    if (post_event) begin
      d.match_event_flag = 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q                       <= '0;
      q.count_low_byte        <= RST_COUNT_LOW;
      q.period_or_high_buffer <= RST_PERIOD_HIGH;
      q.period_buf            <= RST_PERIOD_HIGH;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign PRDATA             = {24'h000000, q.rdata};
  assign PREADY             = 1'b1;
  assign PSLVERR            = access & ~hit;
  assign TIMER_OUT          = q.timer_out;
  assign MATCH_OUTPUT_PULSE = q.pulse;
  assign MATCH_EVENT_FLAG   = q.match_event_flag;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  low_match_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (count_tick && !wr_low && !q.wide_mode_select &&
     (q.count_low_byte == q.period_buf))
    |=> (q.count_low_byte == 8'h00) && (q.pulse == $past(post_event)))
    else $error("8-bit match did not clear low byte");

  wide_carry_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (count_tick && !wr_low && q.wide_mode_select && (q.count_low_byte == 8'hFF))
    |=> (q.count_high == $past(q.count_high) + 8'h01))
    else $error("16-bit carry lost");

  high_snapshot_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (setup && !PWRITE && (PADDR == OFS_COUNT_LOW) && q.wide_mode_select)
    ##1 (rd_low && q.wide_mode_select)
    |=> (q.period_or_high_buffer == $past(q.count_high, 2)))
    else $error("high byte buffer not coherent with low read");

  high_load_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_low && q.wide_mode_select)
    |=> (q.count_high == $past(q.period_or_high_buffer)) &&
        (q.count_low_byte == $past(PWDATA[7:0])))
    else $error("16-bit write did not load both bytes");

  sleep_halt_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (SLEEP && !q.async_count_select && !wr_low)
    |=> $stable(q.count_low_byte) && $stable(q.count_high))
    else $error("synchronous count moved in sleep");

  async_sleep_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (q.async_count_select && pre_tick && !wr_low && q.wide_mode_select)
    |=> (q.count_low_byte != $past(q.count_low_byte)))
    else $error("asynchronous count missed an edge");

  flag_on_event_a: assert property (@(posedge CLK) disable iff (!RST_N)
    post_event |=> q.match_event_flag ##1 (q.match_event_flag ||
                   $past(wr_stat)))
    else $error("flag not set by postscaled event");

  out_toggle_a: assert property (@(posedge CLK) disable iff (!RST_N)
    roll_event && !clr_scalers && (q.post_cnt != q.postscale_select)
    |=> $stable(q.timer_out) && (q.post_cnt == $past(q.post_cnt) + 4'h1))
    else $error("output toggled before postscale count");

  scaler_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_pri || wr_clk) |=> (q.post_cnt == 4'h0) && !q.pend)
    else $error("control write did not clear postscaler");

  // a postscaled event raises the pulse and flips the output together
  post_toggle_a: assert property (@(posedge CLK) disable iff (!RST_N)
    post_event |=> q.pulse && (q.timer_out != $past(q.timer_out)))
    else $error("postscaled event did not toggle output");

  // the pulse lasts one prescaled period: the next plain tick ends it
  pulse_end_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (q.pulse && count_tick && !post_event) |=> !q.pulse)
    else $error("match pulse outlived its period");

  flag_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_stat && PWDATA[STAT_FLAG_BIT] && !post_event) |=> !q.match_event_flag)
    else $error("flag not cleared by write one");

  // 8-bit mode: low byte written straight, compare target reloaded
  low_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_low && !q.wide_mode_select)
    |=> (q.count_low_byte == $past(PWDATA[7:0])) &&
        (q.period_buf == $past(q.period_or_high_buffer)))
    else $error("8-bit low byte write lost");

  period_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_period |=> (q.period_or_high_buffer == $past(PWDATA[7:0])))
    else $error("period write lost");

  // sync counts sit on instruction ticks, so never closer than four clocks
  sync_spacing_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (count_tick && !q.async_count_select)
    |=> (!count_tick || q.async_count_select) [*3])
    else $error("synchronous counts closer than one instruction cycle");
endmodule
